// >>> hw/sipp_pkg.sv
// Constants and types shared by the serial programming port
`default_nettype none
package sipp_pkg;
  // Memory geometry
  localparam int FLASH_BYTES = 2048;
  localparam int EE_BYTES = 128;
  localparam int PAGE_BYTES = 32;
  // Instruction bytes
  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] ENABLE_KEY = 8'h53;
  localparam logic [2:0] ERASE_KEY = 3'h4;
  localparam logic [7:0] OP_RD_PROG = 8'h20;
  localparam logic [7:0] OP_LD_PAGE = 8'h40;
  localparam logic [7:0] OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] HIGH_MASK = 8'hF7; // Drops the high/low byte select
  localparam logic [7:0] ERASED = 8'hFF;
  // Bit positions on the link
  localparam logic [4:0] ECHO_BIT = 5'h10;
  localparam logic [4:0] HEAD_LAST_BIT = 5'h17;
  localparam logic [4:0] READ_BIT = 5'h18;
  localparam logic [4:0] WORD_LAST_BIT = 5'h1F;
  // Self-timed write durations
  localparam real CLK_MHZ = 200.0;
  localparam real FLASH_PAGE_MIN_WAIT_MS = 4.5;
  localparam real EEPROM_BYTE_MIN_WAIT_MS = 9.0;
  localparam real CHIP_ERASE_MIN_WAIT_MS = 9.0;
  localparam int FLASH_WAIT_CYC = int'($ceil(FLASH_PAGE_MIN_WAIT_MS * 1000.0 * CLK_MHZ));
  localparam int EE_WAIT_CYC = int'($ceil(EEPROM_BYTE_MIN_WAIT_MS * 1000.0 * CLK_MHZ));
  localparam int ERASE_WAIT_CYC = int'($ceil(CHIP_ERASE_MIN_WAIT_MS * 1000.0 * CLK_MHZ));
  localparam int WAIT_W = 24;
  // Reset values
  localparam logic [1:0] PIN_SYNC_RST = 2'h3;
  // Self-timed operation in progress
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FLASH = 2'b01,
    ST_EE = 2'b10,
    ST_ERASE = 2'b11
  } sipp_state_e;
  // One four-byte instruction
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } sipp_ins_s;
endpackage : sipp_pkg
`default_nettype wire

// >>> hw/sipp_port.sv
// Serial programming port with flash, page buffer and EEPROM storage
`timescale 1ns/1ps
`default_nettype none
module sipp_port #(
  parameter int FLASH_WAIT = sipp_pkg::FLASH_WAIT_CYC,
  parameter int EE_WAIT = sipp_pkg::EE_WAIT_CYC,
  parameter int ERASE_WAIT = sipp_pkg::ERASE_WAIT_CYC
) (
  // Core clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Programming link
  input wire logic isp_sck_in,
  input wire logic isp_mosi_in,
  input wire logic isp_reset_b_in,
  output logic isp_miso_out,
  // Status
  output logic prog_enabled_out,
  output logic busy_out
);
  import sipp_pkg::*;

  logic [1:0] pin_sync_r;
  logic session_r;
  logic [4:0] bit_cnt_r;
  logic [31:0] shift_r;
  logic [23:0] head_r;
  sipp_ins_s word_r;
  logic head_tgl_r;
  logic word_tgl_r;
  logic [7:0] tx_r;
  logic [2:0] head_sync_r;
  logic [2:0] word_sync_r;
  logic head_evt;
  logic word_evt;
  logic enabled_r;
  logic [7:0] rd_data_r;
  sipp_state_e st_r;
  logic [WAIT_W-1:0] wait_r;
  logic busy_r;
  logic [5:0] busy_page_r;
  logic [6:0] busy_ee_r;
  logic [7:0] ee_data_r;
  logic done;
  logic cmd_ok;
  logic go_erase;
  logic ld_pg;
  logic go_flash;
  logic go_ee;
  logic [10:0] rd_fidx;
  logic [6:0] rd_eidx;
  logic [4:0] pg_idx;
  logic [7:0] flash_r [FLASH_BYTES];
  logic [7:0] ee_r [EE_BYTES];
  logic [7:0] page_r [PAGE_BYTES];

  // Reset pin is asynchronous to the core, so two flops before use
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_sync_r <= PIN_SYNC_RST;
      session_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], isp_reset_b_in};
      session_r <= ~pin_sync_r[1];
    end
  end

  // Link side: held in reset outside a session, which also realigns bytes
  always_ff @(posedge isp_sck_in or negedge session_r) begin
    if (!session_r) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 32'h0000_0000;
      head_r <= 24'h00_0000;
      word_r <= '0;
      head_tgl_r <= 1'b0;
      word_tgl_r <= 1'b0;
    end else begin
      shift_r <= {shift_r[30:0], isp_mosi_in};
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (bit_cnt_r == HEAD_LAST_BIT) begin
        head_r <= {shift_r[22:0], isp_mosi_in};
        head_tgl_r <= ~head_tgl_r;
      end
      if (bit_cnt_r == WORD_LAST_BIT) begin
        word_r <= {shift_r[30:0], isp_mosi_in};
        word_tgl_r <= ~word_tgl_r;
      end
    end
  end

  // Output shifter: last byte echoes back, read data replaces byte four.
  // rd_data_r is taken quasi-static; the core settles it within a few
  // core cycles of byte three, well inside the SCK high phase that follows.
  always_ff @(negedge isp_sck_in or negedge session_r) begin
    if (!session_r) begin
      tx_r <= 8'h00;
    end else if (bit_cnt_r[2:0] != 3'h0) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end else if (bit_cnt_r == READ_BIT) begin
      tx_r <= rd_data_r;
    end else begin
      tx_r <= shift_r[7:0];
    end
  end

  assign isp_miso_out = tx_r[7];

  // Toggle crossings; first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      head_sync_r <= 3'h0;
      word_sync_r <= 3'h0;
    end else begin
      head_sync_r <= {head_sync_r[1:0], head_tgl_r};
      word_sync_r <= {word_sync_r[1:0], word_tgl_r};
    end
  end

  // Gating with the session hides the toggle drop when the link resets
  assign head_evt = session_r && (head_sync_r[2] ^ head_sync_r[1]);
  assign word_evt = session_r && (word_sync_r[2] ^ word_sync_r[1]);

  // Programming enable, lost whenever the session ends
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enabled_r <= 1'b0;
    end else if (!session_r) begin
      enabled_r <= 1'b0;
    end else if (word_evt && word_r.op == OP_ENABLE && word_r.b2 == ENABLE_KEY) begin
      enabled_r <= 1'b1;
    end
  end

  // Instruction decode; writes are dropped without enable or while the array is busy
  assign cmd_ok = word_evt && enabled_r && !busy_r;
  assign go_erase = cmd_ok && word_r.op == OP_ENABLE && word_r.b2[7:5] == ERASE_KEY;
  assign ld_pg = cmd_ok && (word_r.op & HIGH_MASK) == OP_LD_PAGE;
  assign go_flash = cmd_ok && word_r.op == OP_WR_PAGE;
  assign go_ee = cmd_ok && word_r.op == OP_WR_EE;
  assign pg_idx = {word_r.b3[3:0], word_r.op[3]};
  assign done = busy_r && wait_r == WAIT_W'(1);

  // Self-timed write sequencer
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      busy_r <= 1'b0;
      busy_page_r <= 6'h00;
      busy_ee_r <= 7'h00;
      ee_data_r <= 8'h00;
    end else if (go_erase) begin
      st_r <= ST_ERASE;
      wait_r <= WAIT_W'(ERASE_WAIT);
      busy_r <= 1'b1;
    end else if (go_flash) begin
      st_r <= ST_FLASH;
      wait_r <= WAIT_W'(FLASH_WAIT);
      busy_r <= 1'b1;
      busy_page_r <= {word_r.b2[1:0], word_r.b3[7:4]};
    end else if (go_ee) begin
      st_r <= ST_EE;
      wait_r <= WAIT_W'(EE_WAIT);
      busy_r <= 1'b1;
      busy_ee_r <= word_r.b3[6:0];
      ee_data_r <= word_r.b4;
    end else if (done) begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      busy_r <= 1'b0;
    end else if (busy_r) begin
      wait_r <= wait_r - WAIT_W'(1);
    end
  end

  assign busy_out = busy_r;
  assign prog_enabled_out = enabled_r;

  // Page buffer returns to erased after each commit
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        page_r[i] <= ERASED;
      end else if (ld_pg && pg_idx == 5'(i)) begin
        page_r[i] <= word_r.b4;
      end else if (done && st_r == ST_FLASH) begin
        page_r[i] <= ERASED;
      end
    end
  end

  // Flash array; contents change only at the end of the timed write
  for (genvar i = 0; i < FLASH_BYTES; i++) begin : g_flash
    localparam logic [5:0] PG = 6'(i / PAGE_BYTES);
    always_ff @(posedge core_clk_in) begin
      if (done && st_r == ST_ERASE) begin
        flash_r[i] <= ERASED;
      end else if (done && st_r == ST_FLASH && busy_page_r == PG) begin
        flash_r[i] <= page_r[i % PAGE_BYTES];
      end
    end
  end

  // EEPROM array; a byte write overwrites the old value whole
  for (genvar i = 0; i < EE_BYTES; i++) begin : g_ee
    always_ff @(posedge core_clk_in) begin
      if (done && st_r == ST_ERASE) begin
        ee_r[i] <= ERASED;
      end else if (done && st_r == ST_EE && busy_ee_r == 7'(i)) begin
        ee_r[i] <= ee_data_r;
      end
    end
  end

  // Read data for byte four, prepared as soon as byte three lands
  assign rd_fidx = {head_r[9:8], head_r[7:0], head_r[19]};
  assign rd_eidx = head_r[6:0];
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_r <= ERASED;
    end else if (head_evt) begin
      if (!enabled_r) begin
        rd_data_r <= head_r[7:0];
      end else if ((head_r[23:16] & HIGH_MASK) == OP_RD_PROG) begin
        rd_data_r <= (st_r == ST_FLASH && rd_fidx[10:5] == busy_page_r) ?
                     ERASED : flash_r[rd_fidx];
      end else if (head_r[23:16] == OP_RD_EE) begin
        rd_data_r <= (st_r == ST_EE && rd_eidx == busy_ee_r) ?
                     ERASED : ee_r[rd_eidx];
      end else begin
        rd_data_r <= head_r[7:0];
      end
    end
  end

  chk_mosi_sample: assert property (
    @(posedge isp_sck_in) disable iff (!session_r)
    1'b1 |=> shift_r[0] == $past(isp_mosi_in))
    else $error("MOSI bit not captured on rising edge");

  chk_miso_shift: assert property (
    @(negedge isp_sck_in) disable iff (!session_r)
    bit_cnt_r[2:0] != 3'h0 |=> tx_r[7:1] == $past(tx_r[6:0]))
    else $error("MISO did not shift on falling edge");

  chk_enable_echo: assert property (
    @(posedge isp_sck_in) disable iff (!session_r)
    bit_cnt_r == ECHO_BIT |-> tx_r == shift_r[7:0])
    else $error("Second byte not echoed during third");

  chk_session_drop: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !session_r |=> !enabled_r)
    else $error("Enable held outside a session");

  chk_enable_accept: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    word_evt && word_r.op == OP_ENABLE && word_r.b2 == ENABLE_KEY |=> enabled_r)
    else $error("Enable instruction not accepted");

  chk_locked_idle: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !enabled_r && !busy_r |=> !busy_r)
    else $error("Write started before enable");

  chk_erase_all: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    done && st_r == ST_ERASE |=> flash_r[0] == ERASED && ee_r[EE_BYTES-1] == ERASED)
    else $error("Chip erase left data behind");

  chk_page_commit: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    done && st_r == ST_FLASH |=>
      flash_r[{$past(busy_page_r), 5'h00}] == $past(page_r[0]) && !busy_r)
    else $error("Page buffer not committed");

  chk_ee_commit: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    done && st_r == ST_EE |=> ee_r[$past(busy_ee_r)] == $past(ee_data_r))
    else $error("EEPROM byte not written");

  chk_ee_poll: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    head_evt && enabled_r && head_r[23:16] == OP_RD_EE && st_r == ST_EE &&
      rd_eidx == busy_ee_r |=> rd_data_r == ERASED)
    else $error("Busy EEPROM byte did not read FF");

  chk_page_poll: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    head_evt && enabled_r && (head_r[23:16] & HIGH_MASK) == OP_RD_PROG &&
      st_r == ST_FLASH && rd_fidx[10:5] == busy_page_r |=> rd_data_r == ERASED)
    else $error("Busy flash page did not read FF");

  // A load lands in the slot that the instruction names
  chk_page_load: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    ld_pg |=> page_r[$past(pg_idx)] == $past(word_r.b4))
    else $error("Page buffer slot not loaded");

  // Before enable a read hands back byte three, never array data
  chk_locked_read: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    head_evt && !enabled_r |=> rd_data_r == $past(head_r[7:0]))
    else $error("Locked read did not echo byte three");
endmodule : sipp_port
`default_nettype wire

// >>> tb/sipp_prog_model.sv
// Programmer model that drives the serial programming link as master
`timescale 1ns/1ps
`default_nettype none
module sipp_prog_model (
  // Link pins toward the device
  output logic sck_out,
  output logic mosi_out,
  output logic reset_b_out,
  // Serial data back from the device
  input wire logic miso_in
);
  // Power up with the reset pin and the link clock both low
  initial begin
    sck_out = 1'b0;
    reset_b_out = 1'b0;
    mosi_out = 1'b0;
  end

  // Whole instruction, MSB first; 80 ns phases stay well above 3 core cycles
  task automatic xfer(input logic [31:0] ins, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_out = ins[i];
      #80 sck_out = 1'b1;
      rx = {rx[30:0], miso_in};
      #80 sck_out = 1'b0;
    end
    // Idle data line shows no stale bit, and the clock stands low between frames
    mosi_out = ~ins[0];
    #80;
  endtask : xfer

  // Resync by a reset pulse; the settle wait repeats the power-up delay
  task automatic pulse_reset();
    reset_b_out = 1'b1;
    #100 reset_b_out = 1'b0;
    #1003.7;
  endtask : pulse_reset
endmodule : sipp_prog_model
`default_nettype wire

// >>> tb/sipp_port_tb.sv
// Self-checking testbench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module sipp_port_tb;
  import sipp_pkg::*;
  // Short self-timed waits keep the run brief but outlast a polling read
  localparam int WAIT_CYC = 2000;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  wire logic isp_sck, isp_mosi, isp_reset_b, isp_miso, prog_enabled, busy;
  logic [31:0] rx;
  int fails = 0;
  int n_tests = 0;
  // EEPROM rows: address, then data written and expected on read-back
  logic [15:0] ee_rows [3] = '{16'h0500, 16'h055A, 16'h7FA5};
  // Flash rows: read instruction, then expected byte
  logic [39:0] fl_rows [5] = '{40'h20_0050_0034, 40'h28_0050_0012, 40'h20_005F_00CD,
                               40'h28_005F_00AB, 40'h20_0051_00FF};

  // Core clock, 200 MHz
  always #2.5 core_clk_in = ~core_clk_in;

  sipp_port #(.FLASH_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC), .ERASE_WAIT(WAIT_CYC)) i_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .isp_sck_in(isp_sck),
    .isp_mosi_in(isp_mosi), .isp_reset_b_in(isp_reset_b), .isp_miso_out(isp_miso),
    .prog_enabled_out(prog_enabled), .busy_out(busy));

  sipp_prog_model i_prog (.sck_out(isp_sck), .mosi_out(isp_mosi),
    .reset_b_out(isp_reset_b), .miso_in(isp_miso));

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ins(input logic [31:0] w);
    i_prog.xfer(w, rx);
  endtask : ins

  // Bounded wait for the self-timed write to end; waiting keeps off the link
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      $display("ERROR t=%0t write never finished", $time);
    end
    #1.3; // Keeps link edges off the core edges
  endtask : wait_idle

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Watchdog, just under twice the expected run length
  initial begin
    #400000;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1 rst_b_in = 1'b1;
    #1003.7;
    // Before enable: writes refused, reads only echo
    ins(32'hC000_1077);
    check({7'h00, busy}, 8'h00);
    ins(32'hA000_1000);
    check(rx[7:0], 8'h10);
    check({7'h00, prog_enabled}, 8'h00);
    $display("test refused done");
    // Enable with key echoed during byte three
    ins(32'hAC53_0000);
    check(rx[15:8], 8'h53);
    check({7'h00, prog_enabled}, 8'h01);
    // Chip erase clears both arrays
    ins(32'hAC80_0000);
    check({7'h00, busy}, 8'h01);
    wait_idle();
    ins(32'hA000_7F00);
    check(rx[7:0], 8'hFF);
    ins(32'h2000_5000);
    check(rx[7:0], 8'hFF);
    $display("test erase done");
    // EEPROM rows: poll reads FF while busy, then the written byte
    for (int k = 0; k < 3; k++) begin
      ins({16'hC000, ee_rows[k]});
      ins({16'hA000, ee_rows[k][15:8], 8'h00});
      check(rx[7:0], 8'hFF);
      check({7'h00, busy}, 8'h01);
      wait_idle();
      ins({16'hA000, ee_rows[k][15:8], 8'h00});
      check(rx[7:0], ee_rows[k][7:0]);
    end
    $display("test eeprom done");
    // Page load, low before high, first and last word slots
    ins(32'h4000_0034);
    ins(32'h4800_0012);
    ins(32'h4000_0FCD);
    ins(32'h4800_0FAB);
    ins(32'h4C00_5000);
    ins(32'h2000_5F00);
    check(rx[7:0], 8'hFF);
    wait_idle();
    for (int k = 0; k < 5; k++) begin
      ins(fl_rows[k][39:8]);
      check(rx[7:0], fl_rows[k][7:0]);
    end
    $display("test flash done");
    // Reset pulse ends the session; enable must be given again
    i_prog.pulse_reset();
    check({7'h00, prog_enabled}, 8'h00);
    ins(32'hC000_0511);
    check({7'h00, busy}, 8'h00);
    ins(32'hAC53_0000);
    check(rx[15:8], 8'h53);
    ins(32'hA000_0500);
    check(rx[7:0], 8'h5A);
    // Write while busy is ignored; the first write still lands
    ins(32'hC000_0611);
    ins(32'hC000_7E22);
    wait_idle();
    ins(32'hA000_0600);
    check(rx[7:0], 8'h11);
    ins(32'hA000_7E00);
    check(rx[7:0], 8'hFF);
    $display("test resync done");
    finish_test();
  end
endmodule : sipp_port_tb
`default_nettype wire
